// ---- design/tone_signal_ctrl.sv ----
// tone signalling controller: cadence timers for two tone generators,
// fsk caller id serialiser driving oscillator 1, billing tone generator
// with volume envelope. assumes a 16-bit register port on clk_sys and
// a transmit-path level sample from logic on the same clock.
`timescale 1ns/1ps
module tone_signal_ctrl
    import tone_signal_pkg::*;
#(
    parameter int TICK_8K = TICK_8K_CYC,
    parameter int TICK_24K = TICK_24K_CYC,
    parameter int TICK_64K = TICK_64K_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire reg_req_t bus_req,
    output logic [15:0] bus_rdata,
    // transmit path level for the clip detector
    input wire logic [15:0] tx_level,
    // outputs
    output logic irq,
    output logic tone1_on,
    output logic tone2_on,
    output fsk_drive_t fsk_drive,
    output logic [15:0] billing_volume,
    output logic [15:0] billing_dac
);

    // sample strobes: 8 kHz, 24 kHz, 64 kHz
    logic [2:0] tick;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_div
            localparam int DIV = (g == 0) ? TICK_8K :
                (g == 1) ? TICK_24K : TICK_64K;
            logic [15:0] div_reg;
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    div_reg <= 16'h0000;
                    tick[g] <= 1'b0;
                end else if (div_reg == 16'(DIV - 1)) begin
                    div_reg <= 16'h0000;
                    tick[g] <= 1'b1;
                end else begin
                    div_reg <= div_reg + 16'h0001;
                    tick[g] <= 1'b0;
                end
            end
        end
    endgenerate

    logic wr_hit;
    logic [7:0] waddr;
    assign wr_hit = bus_req.wr;
    assign waddr = bus_req.addr;

    // software registers
    logic [IRQ_NUM-1:0] irq_enable_one_reg;
    logic [IRQ_NUM-1:0] irq_vector_one_reg;
    logic [1:0] oscillator_mode_reg;
    logic [7:0] tone_control_reg;
    logic [15:0] active_period_reg [3];
    logic [15:0] inactive_period_reg [3];
    logic [15:0] fsk_coeff_reg [FSK_COEFF_NUM];
    logic [15:0] billing_freq_coeff_reg;
    logic [15:0] billing_amp_coeff_reg;
    logic [15:0] billing_ramp_step_reg;
    logic [15:0] billing_agc_threshold_reg;
    logic [2:0] billing_control_reg;

    logic fsk_mode;
    logic fsk_raw;
    assign fsk_mode = oscillator_mode_reg[MODE_FSK_ENABLE];
    assign fsk_raw = oscillator_mode_reg[MODE_FSK_RAW_BYTE];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_enable_one_reg <= '0;
            oscillator_mode_reg <= 2'h0;
            tone_control_reg <= 8'h00;
            billing_freq_coeff_reg <= 16'h0000;
            billing_amp_coeff_reg <= 16'h0000;
            billing_ramp_step_reg <= 16'h0000;
            billing_agc_threshold_reg <= 16'h0000;
            billing_control_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                active_period_reg[i] <= 16'h0000;
                inactive_period_reg[i] <= 16'h0000;
            end
            for (int i = 0; i < FSK_COEFF_NUM; i++) begin
                fsk_coeff_reg[i] <= 16'h0000;
            end
        end else if (wr_hit) begin
            case (waddr)
                ADDR_IRQ_ENABLE_ONE:
                    irq_enable_one_reg <= bus_req.wdata[IRQ_NUM-1:0];
                ADDR_OSC_MODE: oscillator_mode_reg <= bus_req.wdata[1:0];
                ADDR_TONE_CONTROL: tone_control_reg <= bus_req.wdata[7:0];
                ADDR_OSC1_ACTIVE: active_period_reg[0] <= bus_req.wdata;
                ADDR_OSC1_INACTIVE: inactive_period_reg[0] <= bus_req.wdata;
                ADDR_OSC2_ACTIVE: active_period_reg[1] <= bus_req.wdata;
                ADDR_OSC2_INACTIVE: inactive_period_reg[1] <= bus_req.wdata;
                ADDR_BILL_ACTIVE: active_period_reg[2] <= bus_req.wdata;
                ADDR_BILL_INACTIVE: inactive_period_reg[2] <= bus_req.wdata;
                ADDR_BILL_FREQ: billing_freq_coeff_reg <= bus_req.wdata;
                ADDR_BILL_AMP: billing_amp_coeff_reg <= bus_req.wdata;
                ADDR_BILL_RAMP: billing_ramp_step_reg <= bus_req.wdata;
                ADDR_BILL_AGC: billing_agc_threshold_reg <= bus_req.wdata;
                ADDR_BILL_CONTROL:
                    billing_control_reg <= bus_req.wdata[2:0];
                default: begin
                    if (waddr >= ADDR_FSK_COEFF0 &&
                        waddr < ADDR_FSK_COEFF0 + 8'(FSK_COEFF_NUM)) begin
                        fsk_coeff_reg[3'(waddr - ADDR_FSK_COEFF0)] <=
                            bus_req.wdata;
                    end
                end
            endcase
        end
    end

    // cadence timers: 0 = tone 1, 1 = tone 2, 2 = billing
    logic [2:0] gen_en;
    logic [2:0] ta_en;
    logic [2:0] ti_en;
    logic [2:0] timer_tick;
    logic [2:0] act_expire;
    logic [2:0] inact_expire;
    logic [2:0] gate;
    logic fsk_bit_tick;

    assign gen_en = {billing_control_reg[BILL_GENERATOR_ON],
        tone_control_reg[4 + TONE_ON], tone_control_reg[TONE_ON]};
    assign ta_en = {billing_control_reg[BILL_ACTIVE_TIMER_ON],
        tone_control_reg[4 + TONE_ACTIVE_TIMER_ON],
        tone_control_reg[TONE_ACTIVE_TIMER_ON]};
    assign ti_en = {billing_control_reg[BILL_INACTIVE_TIMER_ON],
        tone_control_reg[4 + TONE_INACTIVE_TIMER_ON],
        tone_control_reg[TONE_INACTIVE_TIMER_ON]};
    // fsk mode clocks oscillator 1's active timer at 24 kHz
    assign timer_tick = {tick[0], tick[0],
        fsk_mode ? tick[1] : tick[0]};
    assign fsk_bit_tick = fsk_mode & act_expire[0];

    generate
        for (g = 0; g < 3; g++) begin : gen_timer
            logic [15:0] count_reg;
            logic inactive_phase_reg;
            logic running_reg;
            logic fsk_timer;
            logic timed;
            assign fsk_timer = (g == 0) && fsk_mode;
            assign timed = ta_en[g] | ti_en[g];
            assign act_expire[g] = gen_en[g] & running_reg & timed &
                ta_en[g] & !inactive_phase_reg & timer_tick[g] &
                (count_reg >= active_period_reg[g]);
            assign inact_expire[g] = gen_en[g] & running_reg &
                inactive_phase_reg & timer_tick[g] &
                (count_reg >= inactive_period_reg[g]);
            assign gate[g] = gen_en[g] & (!timed |
                (running_reg & !inactive_phase_reg));
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    count_reg <= 16'h0000;
                    inactive_phase_reg <= 1'b0;
                    running_reg <= 1'b1;
                end else if (!gen_en[g]) begin
                    count_reg <= 16'h0000;
                    inactive_phase_reg <= 1'b0;
                    running_reg <= 1'b1;
                end else if (act_expire[g]) begin
                    count_reg <= 16'h0000;
                    if (!fsk_timer) begin
                        inactive_phase_reg <= ti_en[g];
                        running_reg <= ti_en[g];
                    end
                end else if (inact_expire[g]) begin
                    count_reg <= 16'h0000;
                    inactive_phase_reg <= 1'b0;
                end else if (timer_tick[g] & running_reg & timed) begin
                    count_reg <= count_reg + 16'h0001;
                end
            end
        end
    endgenerate

    // fsk serialiser
    typedef enum logic [1:0] {
        FSK_IDLE = 2'b01,
        FSK_SEND = 2'b10
    } fsk_state_t;
    fsk_state_t fsk_state_reg;
    logic [7:0] fsk_hold_reg;
    logic fsk_hold_full_reg;
    logic [9:0] fsk_shift_reg;
    logic [3:0] fsk_left_reg;
    logic fsk_symbol_reg;
    logic fsk_load;
    logic fsk_data_wr;
    logic [3:0] seq_len;

    assign fsk_data_wr = wr_hit && waddr == ADDR_FSK_DATA;
    assign seq_len = fsk_raw ? 4'(RAW_LEN) : 4'(FRAMED_LEN);
    assign fsk_load = fsk_bit_tick & fsk_hold_full_reg &
        (fsk_state_reg == FSK_IDLE || fsk_left_reg == 4'h1);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fsk_hold_reg <= 8'h00;
            fsk_hold_full_reg <= 1'b0;
        end else if (fsk_data_wr) begin
            fsk_hold_reg <= bus_req.wdata[7:0];
            fsk_hold_full_reg <= 1'b1;
        end else if (fsk_load) begin
            fsk_hold_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fsk_state_reg <= FSK_IDLE;
            fsk_shift_reg <= 10'h3ff;
            fsk_left_reg <= 4'h0;
            fsk_symbol_reg <= 1'b1;
        end else if (!fsk_mode) begin
            fsk_state_reg <= FSK_IDLE;
            fsk_left_reg <= 4'h0;
            fsk_symbol_reg <= 1'b1;
        end else if (fsk_bit_tick) begin
            case (fsk_state_reg)
                FSK_IDLE: begin
                    if (fsk_load) begin
                        fsk_state_reg <= FSK_SEND;
                        // stop mark, data lsb first, start space
                        fsk_shift_reg <= fsk_raw ? {2'b11, fsk_hold_reg} :
                            {1'b1, fsk_hold_reg, 1'b0};
                        fsk_left_reg <= seq_len;
                    end
                    fsk_symbol_reg <= 1'b1;
                end
                FSK_SEND: begin
                    fsk_symbol_reg <= fsk_shift_reg[0];
                    if (fsk_load) begin
                        fsk_shift_reg <= fsk_raw ? {2'b11, fsk_hold_reg} :
                            {1'b1, fsk_hold_reg, 1'b0};
                        fsk_left_reg <= seq_len;
                    end else if (fsk_left_reg == 4'h1) begin
                        fsk_state_reg <= FSK_IDLE;
                        fsk_left_reg <= 4'h0;
                    end else begin
                        fsk_shift_reg <= {1'b1, fsk_shift_reg[9:1]};
                        fsk_left_reg <= fsk_left_reg - 4'h1;
                    end
                end
                default: fsk_state_reg <= FSK_IDLE;
            endcase
        end
    end

    // oscillator 1 drive, updated at the 24 kHz sample rate
    logic fsk_last_reg;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            fsk_drive <= '0;
            fsk_last_reg <= 1'b0;
        end else if (tick[1]) begin
            fsk_last_reg <= fsk_symbol_reg;
            fsk_drive.symbol <= fsk_symbol_reg;
            fsk_drive.freq <= COEFF_KEEP_MASK & (fsk_symbol_reg ?
                fsk_coeff_reg[FSK_MARK_FREQ] :
                fsk_coeff_reg[FSK_SPACE_FREQ]);
            fsk_drive.amp <= COEFF_KEEP_MASK & (fsk_symbol_reg ?
                fsk_coeff_reg[FSK_MARK_AMP] :
                fsk_coeff_reg[FSK_SPACE_AMP]);
            fsk_drive.trans_valid <= fsk_mode &
                (fsk_symbol_reg != fsk_last_reg);
            fsk_drive.trans_high <= COEFF_KEEP_MASK & (fsk_symbol_reg ?
                fsk_coeff_reg[FSK_RISE_HIGH] :
                fsk_coeff_reg[FSK_FALL_HIGH]);
            fsk_drive.trans_low <= COEFF_KEEP_MASK & (fsk_symbol_reg ?
                fsk_coeff_reg[FSK_RISE_LOW] :
                fsk_coeff_reg[FSK_FALL_LOW]);
        end else begin
            fsk_drive.trans_valid <= 1'b0;
        end
    end

    // interrupt pending flags; a set in the clearing cycle wins
    logic [IRQ_NUM-1:0] irq_set;
    logic [IRQ_NUM-1:0] irq_clr;
    assign irq_set = {fsk_load, inact_expire[2], act_expire[2],
        inact_expire[1], act_expire[1],
        inact_expire[0], act_expire[0] & !fsk_mode};
    assign irq_clr = (wr_hit && waddr == ADDR_IRQ_VECTOR_ONE) ?
        bus_req.wdata[IRQ_NUM-1:0] : '0;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_vector_one_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_vector_one_reg <= (irq_vector_one_reg & ~irq_clr) |
                irq_set;
            irq <= |(irq_vector_one_reg & irq_enable_one_reg);
        end
    end

    // billing tone envelope
    logic [15:0] volume_reg;
    logic billing_on;
    logic [16:0] vol_up;
    logic clipped;
    assign billing_on = gate[2];
    assign vol_up = {1'b0, volume_reg} + {1'b0, billing_ramp_step_reg};
    assign clipped = tx_level > billing_agc_threshold_reg;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            volume_reg <= 16'h0000;
        end else if (tick[0]) begin
            if (billing_on) begin
                if (!clipped) begin
                    volume_reg <= (vol_up > {1'b0, VOLUME_FULL}) ?
                        VOLUME_FULL : vol_up[15:0];
                end
            end else if (volume_reg > billing_ramp_step_reg) begin
                volume_reg <= volume_reg - billing_ramp_step_reg;
            end else begin
                volume_reg <= 16'h0000;
            end
        end
    end

    // billing resonant oscillator at 64 kHz: y = 2c*y1 - y2
    logic signed [15:0] y1_reg;
    logic signed [15:0] y2_reg;
    logic signed [31:0] coeff_prod;
    logic signed [31:0] env_prod;
    assign coeff_prod = $signed(COEFF_KEEP_MASK & billing_freq_coeff_reg)
        * y1_reg;
    assign env_prod = y1_reg * $signed(volume_reg);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            y1_reg <= 16'sh0000;
            y2_reg <= 16'sh0000;
        end else if (!billing_on && volume_reg == 16'h0000) begin
            y1_reg <= $signed(billing_amp_coeff_reg);
            y2_reg <= 16'sh0000;
        end else if (tick[2]) begin
            y1_reg <= 16'(coeff_prod >>> 13) - y2_reg;
            y2_reg <= y1_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            billing_dac <= 16'h0000;
            billing_volume <= 16'h0000;
            tone1_on <= 1'b0;
            tone2_on <= 1'b0;
        end else begin
            billing_dac <= 16'(env_prod >>> 15);
            billing_volume <= volume_reg;
            tone1_on <= gate[0];
            tone2_on <= gate[1];
        end
    end

    // register read port, data valid in the following cycle only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_rdata <= 16'h0000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_IRQ_ENABLE_ONE: bus_rdata <= 16'(irq_enable_one_reg);
                ADDR_IRQ_VECTOR_ONE:
                    bus_rdata <= 16'(irq_vector_one_reg);
                ADDR_OSC_MODE: bus_rdata <= 16'(oscillator_mode_reg);
                ADDR_TONE_CONTROL: bus_rdata <= 16'(tone_control_reg);
                ADDR_OSC1_ACTIVE: bus_rdata <= active_period_reg[0];
                ADDR_OSC1_INACTIVE: bus_rdata <= inactive_period_reg[0];
                ADDR_OSC2_ACTIVE: bus_rdata <= active_period_reg[1];
                ADDR_OSC2_INACTIVE: bus_rdata <= inactive_period_reg[1];
                ADDR_BILL_ACTIVE: bus_rdata <= active_period_reg[2];
                ADDR_BILL_INACTIVE: bus_rdata <= inactive_period_reg[2];
                ADDR_FSK_DATA: bus_rdata <= 16'(fsk_hold_reg);
                ADDR_BILL_FREQ: bus_rdata <= billing_freq_coeff_reg;
                ADDR_BILL_AMP: bus_rdata <= billing_amp_coeff_reg;
                ADDR_BILL_RAMP: bus_rdata <= billing_ramp_step_reg;
                ADDR_BILL_AGC: bus_rdata <= billing_agc_threshold_reg;
                ADDR_BILL_CONTROL: bus_rdata <= 16'({
                    volume_reg != 16'h0000, billing_control_reg});
                ADDR_BILL_VOLUME: bus_rdata <= volume_reg;
                default: begin
                    if (bus_req.addr >= ADDR_FSK_COEFF0 && bus_req.addr <
                        ADDR_FSK_COEFF0 + 8'(FSK_COEFF_NUM)) begin
                        bus_rdata <= fsk_coeff_reg[
                            3'(bus_req.addr - ADDR_FSK_COEFF0)];
                    end else begin
                        bus_rdata <= 16'h0000;
                    end
                end
            endcase
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

endmodule

// ---- design/tone_signal_pkg.sv ----
// package for the tone signalling controller: register map, field
// positions, tick timing and the bundles that cross the module ports.
// assumes a 100 MHz system clock and a 16-bit register port.
package tone_signal_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_8K_NS = 125000;
    localparam int TICK_24K_NS = 41660;
    localparam int TICK_64K_NS = 15625;
    localparam int TICK_8K_CYC = TICK_8K_NS / CLK_PERIOD_NS;
    localparam int TICK_24K_CYC = TICK_24K_NS / CLK_PERIOD_NS;
    localparam int TICK_64K_CYC = TICK_64K_NS / CLK_PERIOD_NS;

    localparam logic [7:0] ADDR_IRQ_ENABLE_ONE = 8'h00;
    localparam logic [7:0] ADDR_IRQ_VECTOR_ONE = 8'h01;
    localparam logic [7:0] ADDR_OSC_MODE = 8'h02;
    localparam logic [7:0] ADDR_TONE_CONTROL = 8'h03;
    localparam logic [7:0] ADDR_OSC1_ACTIVE = 8'h04;
    localparam logic [7:0] ADDR_OSC1_INACTIVE = 8'h05;
    localparam logic [7:0] ADDR_OSC2_ACTIVE = 8'h06;
    localparam logic [7:0] ADDR_OSC2_INACTIVE = 8'h07;
    localparam logic [7:0] ADDR_FSK_DATA = 8'h08;
    localparam logic [7:0] ADDR_FSK_COEFF0 = 8'h09;
    localparam logic [7:0] ADDR_BILL_FREQ = 8'h11;
    localparam logic [7:0] ADDR_BILL_AMP = 8'h12;
    localparam logic [7:0] ADDR_BILL_RAMP = 8'h13;
    localparam logic [7:0] ADDR_BILL_AGC = 8'h14;
    localparam logic [7:0] ADDR_BILL_ACTIVE = 8'h15;
    localparam logic [7:0] ADDR_BILL_INACTIVE = 8'h16;
    localparam logic [7:0] ADDR_BILL_CONTROL = 8'h17;
    localparam logic [7:0] ADDR_BILL_VOLUME = 8'h18;

    // fsk coefficient order after ADDR_FSK_COEFF0
    localparam int FSK_SPACE_FREQ = 0;
    localparam int FSK_MARK_FREQ = 1;
    localparam int FSK_SPACE_AMP = 2;
    localparam int FSK_MARK_AMP = 3;
    localparam int FSK_RISE_HIGH = 4;
    localparam int FSK_RISE_LOW = 5;
    localparam int FSK_FALL_HIGH = 6;
    localparam int FSK_FALL_LOW = 7;
    localparam int FSK_COEFF_NUM = 8;

    // irq vector / enable bit positions
    localparam int IRQ_TONE1_ACTIVE = 0;
    localparam int IRQ_TONE1_INACTIVE = 1;
    localparam int IRQ_TONE2_ACTIVE = 2;
    localparam int IRQ_TONE2_INACTIVE = 3;
    localparam int IRQ_BILL_ACTIVE = 4;
    localparam int IRQ_BILL_INACTIVE = 5;
    localparam int IRQ_FSK_BYTE = 6;
    localparam int IRQ_NUM = 7;

    // oscillator_mode_reg fields
    localparam int MODE_FSK_ENABLE = 0;
    localparam int MODE_FSK_RAW_BYTE = 1;
    // tone control fields, generator n at 4*n
    localparam int TONE_ON = 0;
    localparam int TONE_ACTIVE_TIMER_ON = 1;
    localparam int TONE_INACTIVE_TIMER_ON = 2;
    // billing control fields; bits 0-2 in billing_control_reg, bit 3 read-only (volume nonzero)
    localparam int BILL_ACTIVE_TIMER_ON = 0;
    localparam int BILL_INACTIVE_TIMER_ON = 1;
    localparam int BILL_GENERATOR_ON = 2;
    localparam int BILL_WAVEFORM_PRESENT = 3;

    localparam logic [15:0] VOLUME_FULL = 16'h7fff;
    localparam logic [15:0] COEFF_KEEP_MASK = 16'hfff8;
    localparam int FRAMED_LEN = 10;
    localparam int RAW_LEN = 8;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic symbol;
        logic [15:0] freq;
        logic [15:0] amp;
        logic trans_valid;
        logic [15:0] trans_high;
        logic [15:0] trans_low;
    } fsk_drive_t;

endpackage

// ---- tb/fsk_callerid_and_metering_tones_test.sv ----
// testbench for the tone signalling controller with short ticks.
// assumes the register map and bit positions of tone_signal_pkg.
`timescale 1ns/1ps
module fsk_callerid_and_metering_tones_test;
    import tone_signal_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic loud = 1'b0;
    reg_req_t bus_req = '0;
    logic [15:0] bus_rdata, tx_level, billing_volume, billing_dac, d;
    logic irq, tone1_on, tone2_on;
    fsk_drive_t fsk_drive;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    tone_signal_ctrl #(.TICK_8K(20), .TICK_24K(7), .TICK_64K(3))
        tone_signal_ctrl_i (.clk_sys(clk_sys), .reset(reset),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .tx_level(tx_level),
        .irq(irq), .tone1_on(tone1_on), .tone2_on(tone2_on),
        .fsk_drive(fsk_drive), .billing_volume(billing_volume),
        .billing_dac(billing_dac));
    tone_signal_line_model tone_signal_line_model_i (.loud(loud),
        .tx_level(tx_level));
    initial forever #5 clk_sys = ~clk_sys;
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(posedge clk_sys);
        d = bus_rdata;
    endtask
    task automatic tone_scenario;
        rd(8'hff);
        check(d === 16'h0, "unmapped read");
        wr(ADDR_IRQ_ENABLE_ONE, 16'h0001);
        wr(ADDR_OSC1_ACTIVE, 16'h0002);
        wr(ADDR_OSC2_ACTIVE, 16'h0002);
        wr(ADDR_OSC2_INACTIVE, 16'h0002);
        // tone 1 one-shot; tone 2 cadence, 6 or 7 ticks in: active again
        wr(ADDR_TONE_CONTROL, 16'h0073);
        repeat (130) @(posedge clk_sys);
        check(irq === 1'b1 && tone1_on === 1'b0, "tone expiry");
        check(tone2_on === 1'b1, "cadence active again");
        rd(ADDR_IRQ_VECTOR_ONE);
        check(d[3:0] === 4'hd, "pending flags");
        wr(ADDR_IRQ_VECTOR_ONE, 16'h000d);
        rd(ADDR_IRQ_VECTOR_ONE);
        check(d[3:0] === 4'h0 && irq === 1'b0, "pending clear");
        wr(ADDR_TONE_CONTROL, 16'h0000);
        wr(ADDR_IRQ_ENABLE_ONE, 16'h0000);
    endtask
    task automatic billing_scenario;
        wr(ADDR_BILL_RAMP, 16'h3000);
        wr(ADDR_BILL_AGC, 16'h0800);
        wr(ADDR_BILL_AMP, 16'h4000);
        wr(ADDR_BILL_CONTROL, 16'h0004);
        repeat (100) @(posedge clk_sys);
        check(billing_volume === VOLUME_FULL, "attack");
        // zero frequency coefficient: samples +a, 0, -a, 0 at full volume
        for (int i = 0; i < 12 && billing_dac === 16'h0; i++)
            @(posedge clk_sys);
        check(billing_dac inside {16'h3fff, 16'hc000}, "product");
        rd(ADDR_BILL_CONTROL);
        check(d[3] === 1'b1, "present");
        wr(ADDR_BILL_CONTROL, 16'h0000);
        loud <= 1'b1;
        repeat (100) @(posedge clk_sys);
        check(billing_volume === 16'h0, "decay");
        wr(ADDR_BILL_CONTROL, 16'h0004);
        repeat (100) @(posedge clk_sys);
        check(billing_volume === 16'h0, "clip hold");
        wr(ADDR_IRQ_ENABLE_ONE, 16'h0010);
        wr(ADDR_BILL_ACTIVE, 16'h0001);
        wr(ADDR_BILL_CONTROL, 16'h0005);
        repeat (60) @(posedge clk_sys);
        rd(ADDR_IRQ_VECTOR_ONE);
        check(d[5:4] === 2'b01 && irq === 1'b1, "billing timer");
    endtask
    // bit period 2 ticks of 7 cycles; samples mid-bit from the first space
    task automatic fsk_bits(input logic [9:0] bits, input int n);
        logic [15:0] f;
        for (int i = 0; i < 100 && fsk_drive.symbol !== 1'b0; i++)
            @(posedge clk_sys);
        repeat (7) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            f = bits[i] ? 16'h5670 : 16'h1230;
            check(fsk_drive.symbol === bits[i], "fsk bit");
            check(fsk_drive.freq === f, "fsk coefficient");
            repeat (14) @(posedge clk_sys);
        end
    endtask
    task automatic fsk_scenario;
        wr(ADDR_IRQ_ENABLE_ONE, 16'h0040);
        wr(ADDR_OSC_MODE, 16'h0001);
        wr(ADDR_OSC1_ACTIVE, 16'h0001);
        wr(ADDR_FSK_COEFF0 + 8'(FSK_SPACE_FREQ), 16'h1234);
        wr(ADDR_FSK_COEFF0 + 8'(FSK_MARK_FREQ), 16'h5677);
        wr(ADDR_FSK_DATA, 16'h00a5);
        wr(ADDR_TONE_CONTROL, 16'h0003);
        fsk_bits({1'b1, 8'ha5, 1'b0}, 10);
        check(irq === 1'b1, "byte request");
        wr(ADDR_IRQ_VECTOR_ONE, 16'h0040);
        wr(ADDR_OSC_MODE, 16'h0003);
        wr(ADDR_FSK_DATA, 16'h005a);
        check(irq === 1'b0, "request cleared");
        fsk_bits({2'b11, 8'h5a}, 9);
        check(irq === 1'b1, "raw byte request");
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        tone_scenario();
        billing_scenario();
        fsk_scenario();
        conclude();
    end
endmodule

// ---- tb/tone_signal_ctrl_assertions.sv ----
// port checker for the tone signalling controller.
// assumes it is bound onto tone_signal_ctrl with its port names.
`timescale 1ns/1ps
module tone_signal_ctrl_assertions
    import tone_signal_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // register port
    input wire reg_req_t bus_req,
    input wire logic [15:0] bus_rdata,
    // outputs
    input wire logic irq,
    input wire logic tone1_on,
    input wire logic tone2_on,
    input wire fsk_drive_t fsk_drive,
    input wire logic [15:0] billing_volume
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (
        !$past(bus_req.rd) |-> bus_rdata == 16'h0)
        else $error("read data outside read slot");
    a_coeff_bits: assert property (
        (fsk_drive.freq[2:0] | fsk_drive.amp[2:0]) == 3'h0)
        else $error("coefficient low bits set");
    a_trans_pulse: assert property (
        fsk_drive.trans_valid |=> !fsk_drive.trans_valid)
        else $error("transition pulse too long");
    a_trans_symbol: assert property (
        fsk_drive.trans_valid |-> fsk_drive.symbol != $past(fsk_drive.symbol))
        else $error("transition without symbol change");
    a_irq_masked: assert property (
        bus_req.wr && bus_req.addr == ADDR_IRQ_ENABLE_ONE
        && bus_req.wdata[6:0] == 7'h0 |-> ##2 !irq)
        else $error("irq with all enables clear");
    a_present_flag: assert property (
        bus_req.rd && bus_req.addr == ADDR_BILL_CONTROL |=>
        bus_rdata[BILL_WAVEFORM_PRESENT] == (billing_volume != 16'h0))
        else $error("present flag wrong");
    a_volume_ceiling: assert property (
        billing_volume <= VOLUME_FULL)
        else $error("volume above full scale");
    a_tone_off: assert property (
        bus_req.wr && bus_req.addr == ADDR_TONE_CONTROL
        && bus_req.wdata == 16'h0 |-> ##2 !tone1_on && !tone2_on)
        else $error("tone still on after disable");
endmodule
bind tone_signal_ctrl tone_signal_ctrl_assertions
    tone_signal_ctrl_assertions_i (.*);

// ---- tb/tone_signal_line_model.sv ----
// line side model: transmit path level seen by the clip detector.
// assumes the bench raises loud to model a level near clipping.
`timescale 1ns/1ps
module tone_signal_line_model (
    // control from the bench
    input wire logic loud,
    // level into the design
    output logic [15:0] tx_level
);
    assign tx_level = loud ? 16'h1000 : 16'h0010;
endmodule
